// ### design/uep_endpoints.sv
// uep_endpoints.sv: endpoint transaction engine with its register slave
//
// How it works
// - endpoint zero is fixed as an enabled control endpoint for enumeration
// - setup and control traffic only on single-bank endpoints
// - isochronous endpoints are served only when configured dual-bank
// - control transfer is setup, optional data stages, then opposite status
// - forced stall answers IN and OUT tokens with a stall handshake
// - setup sets the IN toggle so the status packet goes as DATA1
// - setup packets are always acknowledged and set the setup flag
// - setup flag keeps an interrupt pending, gated by the endpoint's bit in the interrupt enable register
// - arguments come by OUT, results leave by IN, status closes
// - each byte written to the data register is appended to the packet until the bank is readied or holds DEPTH bytes
// - host ACK sets transmit-complete, frees the bank, keeps interrupt pending
// - dual-bank endpoint: firmware fills one bank while the other is sent
// - after transmit-complete firmware readies the second bank, first frees
// - IN token with no ready bank is answered with NAK
// - OUT packet is NAKed while the single bank is held by firmware
`timescale 1ns/10ps
module uep_endpoints
    import uep_pkg::*;
#(
    parameter int NUM_EP = 4,
    parameter int DEPTH  = 64
) (
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic                ce,
    input  wire logic [7:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    input  wire logic                sie_tok_valid,
    input  wire logic [1:0]          sie_tok_pid,
    input  wire logic [TOK_EP_W-1:0] sie_tok_ep,
    input  wire logic                sie_rx_valid,
    input  wire logic [7:0]          sie_rx_data,
    input  wire logic                sie_rx_done,
    input  wire logic                sie_rx_err,
    output logic                     sie_tx_valid,
    output logic      [7:0]          sie_tx_data,
    output logic                     sie_tx_last,
    output logic                     sie_tx_empty,
    output logic                     sie_tx_data1,
    input  wire logic                sie_tx_ready,
    input  wire logic                sie_host_ack,
    input  wire logic                sie_host_timeout,
    output logic                     sie_hs_valid,
    output logic      [1:0]          sie_hs_code,
    output logic                     ep_irq
);
    // ==========================================================
    // geometry
    localparam int EW = $clog2(NUM_EP);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam int AW = EW + 1 + PW;
    localparam logic [CW-1:0]     DEPTH_C = CW'(DEPTH);
    localparam logic [NUM_EP-1:0] EN_RST  = NUM_EP'(1) << DEFAULT_CTRL_EP;

    if (NUM_EP < 2 || NUM_EP > 8 || (NUM_EP & (NUM_EP - 1)) != 0 ||
        DEPTH < 8 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("uep_endpoints: NUM_EP must be 2..8 and DEPTH a power of two >= 8");
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // ==========================================================
    // state
    logic [NUM_EP-1:0]      txc_r, rxo_r, setup_r, stall_r, dual_r, en_r, tog_r;
    logic [NUM_EP-1:0]      cbank_r, ubank_r, irq_en_r;
    logic [NUM_EP-1:0][1:0] type_r, full_r;
    logic [CW-1:0]          cnt_r [NUM_EP][2];
    logic [CW-1:0]          crd_r [NUM_EP];
    logic [NUM_EP-1:0]      txc_nxt, rxo_nxt, setup_nxt, stall_nxt, dual_nxt, en_nxt;
    logic [NUM_EP-1:0]      tog_nxt, cbank_nxt, ubank_nxt;
    logic [NUM_EP-1:0][1:0] type_nxt, full_nxt;
    logic [CW-1:0]          cnt_nxt [NUM_EP][2];
    logic [CW-1:0]          crd_nxt [NUM_EP];
    uep_state_t             st_r;
    uep_bus_t               bus_r;
    logic [EW-1:0]          cur_ep_r;
    logic                   rx_setup_r, rx_nak_r, rx_stall_r, tx_bank_r;
    logic [CW-1:0]          rx_cnt_r, tx_ptr_r, tx_len_r;
    logic [31:0]            rdata_r;
    logic                   hs_valid_r, irq_r;
    logic [1:0]             hs_code_r;

    uep_mem_if #(.AW(AW), .DW(8)) mem_bus ();

    uep_bank_mem #(.AW(AW), .DW(8)) u_mem (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .m      (mem_bus.mem)
    );

    // ==========================================================
    // decoding helpers
    function automatic logic [31:0] csr_view(input logic [EW-1:0] e);
        logic [31:0] v;
        v                  = '0;
        v[CSR_TXC]         = txc_r[e];
        v[CSR_RXO]         = rxo_r[e];
        v[CSR_SETUP]       = setup_r[e];
        v[CSR_STALL]       = stall_r[e];
        v[CSR_PKTRDY]      = full_r[e][ubank_r[e]];
        v[CSR_DUAL]        = dual_r[e];
        v[CSR_TYPE +: 2]   = type_r[e];
        v[CSR_TOG]         = tog_r[e];
        v[CSR_EN]          = en_r[e];
        v[CSR_CNT +: CW]   = cnt_r[e][0];
        return v;
    endfunction

    // control needs one bank, isochronous needs two
    function automatic logic cfg_ok(input logic [EW-1:0] e);
        return en_r[e] && !(type_r[e] == TYPE_CTRL && dual_r[e]) &&
               !(type_r[e] == TYPE_ISO && !dual_r[e]);
    endfunction

    // ==========================================================
    // register bus slave
    logic [31:0]    csr_sel;
    wire            req      = avs_read | avs_write;
    wire [EW-1:0]   a_ep     = avs_address[EP_SEL_LO +: EW];
    wire            a_ok     = (avs_address & ALIGN_MASK) == 8'h00;
    wire            a_in_ep  = a_ok && avs_address < 8'(NUM_EP * EP_STRIDE);
    wire            a_fdr    = a_in_ep && avs_address[FDR_SEL_BIT];
    wire            a_csr    = a_in_ep && !avs_address[FDR_SEL_BIT];
    wire [31:0]     wmask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0]     wd       = (csr_sel & ~wmask) | (avs_writedata & wmask);
    wire            eng_rd   = st_r == ST_TX_LOAD || st_r == ST_TX_SEND;
    wire            eng_we   = st_r == ST_RX && sie_rx_valid && !rx_nak_r && !rx_stall_r &&
                               rx_cnt_r < DEPTH_C;
    wire            wr_clash = avs_write && a_fdr && eng_we;
    wire            done     = bus_r == BUS_DONE && ce && !wr_clash;
    wire            wr_go    = avs_write && done;
    wire            rd_go    = avs_read && done;
    wire            csr_wr   = wr_go && a_csr;
    wire            fdr_wr   = wr_go && a_fdr && avs_byteenable[0];
    wire            fdr_rd   = rd_go && a_fdr;
    wire            irq_en_w = wr_go && avs_address == IRQ_EN_ADDR;
    wire [NUM_EP-1:0] pend   = txc_r | rxo_r | setup_r;
    wire [31:0]     rd_mux   = a_fdr ? {24'h000000, mem_bus.rdata} :
                               a_csr ? csr_sel :
                               avs_address == IRQ_EN_ADDR ? 32'(irq_en_r) :
                               avs_address == IRQ_PEND_ADDR ? 32'(pend) : 32'h00000000;

    assign avs_waitrequest = req && !done;
    assign avs_readdata    = rdata_r;

    // a process, not an assign: it must wake on the flags that the function reads
    always_comb csr_sel = csr_view(a_ep);

    // the issue phase of a data register read waits while the engine owns the read port
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_r <= BUS_ISSUE;
        end else if (ce) begin
            case (bus_r)
                BUS_ISSUE: if (req && !(avs_read && a_fdr && eng_rd)) bus_r <= BUS_FETCH;
                BUS_FETCH: bus_r <= BUS_DONE;
                BUS_DONE:  if (!wr_clash) bus_r <= BUS_ISSUE;
                default:   bus_r <= BUS_ISSUE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= '0;
        end else if (ce && bus_r == BUS_FETCH) begin
            rdata_r <= rd_mux;
        end
    end

    // ==========================================================
    // memory port: serial engine first, firmware in the gaps
    assign mem_bus.we    = eng_we | fdr_wr;
    assign mem_bus.waddr = eng_we ? {cur_ep_r, 1'b0, rx_cnt_r[PW-1:0]} :
                           {a_ep, cbank_r[a_ep], cnt_r[a_ep][cbank_r[a_ep]][PW-1:0]};
    assign mem_bus.wdata = eng_we ? sie_rx_data : avs_writedata[7:0];
    assign mem_bus.raddr = eng_rd ? {cur_ep_r, tx_bank_r, tx_ptr_r[PW-1:0]} :
                           {a_ep, 1'b0, crd_r[a_ep][PW-1:0]};

    // ==========================================================
    // transaction events
    wire tok_ok   = sie_tok_valid && sie_tok_ep < TOK_EP_W'(NUM_EP) &&
                    cfg_ok(sie_tok_ep[EW-1:0]);
    wire [EW-1:0] tep = sie_tok_ep[EW-1:0];
    wire rx_end   = st_r == ST_RX && sie_rx_done;
    wire ev_setup = rx_end && rx_setup_r;
    wire ev_out   = rx_end && !rx_setup_r && !rx_nak_r && !rx_stall_r;
    wire ev_ack   = st_r == ST_WAIT_ACK && sie_host_ack;
    wire tx_end   = tx_len_r == '0 || tx_ptr_r == tx_len_r - CW'(1);

    // ==========================================================
    // per-endpoint next state
    for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
        wire here = cur_ep_r == EW'(e);
        wire cw   = csr_wr && a_ep == EW'(e);
        wire pr   = cw && wd[CSR_PKTRDY] && !full_r[e][cbank_r[e]];
        wire rel  = ev_ack && here;
        wire fw   = fdr_wr && a_ep == EW'(e);
        wire frd  = fdr_rd && a_ep == EW'(e);
        wire rcv  = (ev_setup || ev_out) && here;
        // handing bank zero back empties it, so a status IN packet goes out with no data
        wire frees = cw && ((setup_r[e] && !wd[CSR_SETUP]) || (rxo_r[e] && !wd[CSR_RXO]));
        // hardware set wins over a firmware clear in the same cycle
        assign txc_nxt[e]   = rel | (txc_r[e] & ~(cw & ~wd[CSR_TXC]));
        assign rxo_nxt[e]   = (ev_out & here) | (rxo_r[e] & ~(cw & ~wd[CSR_RXO]));
        assign setup_nxt[e] = (ev_setup & here) |
                              (setup_r[e] & ~(cw & ~wd[CSR_SETUP]));
        assign stall_nxt[e] = cw ? wd[CSR_STALL] : stall_r[e] & ~(ev_setup & here);
        assign tog_nxt[e]   = (ev_setup & here) ? 1'b1 : tog_r[e] ^ rel;
        // banks restart at zero whenever dual-bank is switched off
        assign ubank_nxt[e] = dual_nxt[e] & (ubank_r[e] ^ (rel & dual_r[e]));
        assign cbank_nxt[e] = dual_nxt[e] & (cbank_r[e] ^ (pr & dual_r[e]));
        if (e == DEFAULT_CTRL_EP) begin : g_ctrl
            assign en_nxt[e]   = 1'b1;
            assign dual_nxt[e] = 1'b0;
            assign type_nxt[e] = TYPE_CTRL;
        end else begin : g_cfg
            assign en_nxt[e]   = cw ? wd[CSR_EN] : en_r[e];
            assign dual_nxt[e] = cw ? wd[CSR_DUAL] : dual_r[e];
            assign type_nxt[e] = cw ? wd[CSR_TYPE +: 2] : type_r[e];
        end
        assign crd_nxt[e] = rcv ? '0 : crd_r[e] + CW'(frd);
        for (genvar b = 0; b < 2; b++) begin : g_bank
            wire mine = ubank_r[e] == 1'(b);
            assign full_nxt[e][b] = (full_r[e][b] & ~(rel & mine)) |
                                    (pr & (cbank_r[e] == 1'(b)));
            assign cnt_nxt[e][b] =
                (rcv && b == 0)  ? rx_cnt_r :
                (rel && mine)    ? '0 :
                (frees && b == 0) ? '0 :
                (fw && cbank_r[e] == 1'(b) && !full_r[e][b] && cnt_r[e][b] < DEPTH_C) ?
                                   cnt_r[e][b] + CW'(1) : cnt_r[e][b];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {txc_r, rxo_r, setup_r, stall_r, tog_r} <= '0;
            {dual_r, cbank_r, ubank_r, irq_en_r}    <= '0;
            en_r   <= EN_RST;
            type_r <= '0;
            full_r <= '0;
            cnt_r  <= '{default: '0};
            crd_r  <= '{default: '0};
            irq_r  <= 1'b0;
        end else if (ce) begin
            {txc_r, rxo_r, setup_r, stall_r, tog_r} <= {txc_nxt, rxo_nxt, setup_nxt,
                                                        stall_nxt, tog_nxt};
            {dual_r, cbank_r, ubank_r, en_r} <= {dual_nxt, cbank_nxt, ubank_nxt, en_nxt};
            type_r <= type_nxt;
            full_r <= full_nxt;
            cnt_r  <= cnt_nxt;
            crd_r  <= crd_nxt;
            if (irq_en_w) irq_en_r <= avs_writedata[NUM_EP-1:0];
            irq_r <= |(pend & irq_en_r);
        end
    end

    // ==========================================================
    // serial engine transaction sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= ST_IDLE;
            {cur_ep_r, rx_setup_r, rx_nak_r, rx_stall_r, tx_bank_r} <= '0;
            {rx_cnt_r, tx_ptr_r, tx_len_r} <= '0;
            hs_valid_r <= 1'b0;
            hs_code_r  <= HS_ACK;
        end else if (ce) begin
            hs_valid_r <= 1'b0;
            case (st_r)
                ST_IDLE: if (tok_ok) begin
                    cur_ep_r <= tep;
                    rx_cnt_r <= '0;
                    if (sie_tok_pid == TOK_SETUP && type_r[tep] == TYPE_CTRL) begin
                        rx_setup_r <= 1'b1;
                        {rx_nak_r, rx_stall_r} <= 2'b00;
                        st_r <= ST_RX;
                    end else if (sie_tok_pid == TOK_OUT) begin
                        rx_setup_r <= 1'b0;
                        rx_stall_r <= stall_r[tep];
                        rx_nak_r   <= setup_r[tep] | rxo_r[tep] | full_r[tep][0];
                        st_r <= ST_RX;
                    end else if (sie_tok_pid == TOK_IN) begin
                        hs_valid_r <= stall_r[tep] || !full_r[tep][ubank_r[tep]];
                        hs_code_r  <= stall_r[tep] ? HS_STALL : HS_NAK;
                        if (!stall_r[tep] && full_r[tep][ubank_r[tep]]) begin
                            tx_bank_r <= ubank_r[tep];
                            tx_len_r  <= cnt_r[tep][ubank_r[tep]];
                            tx_ptr_r  <= '0;
                            st_r      <= ST_TX_LOAD;
                        end
                    end
                end
                ST_RX: begin
                    if (eng_we) rx_cnt_r <= rx_cnt_r + CW'(1);
                    if (sie_rx_err) begin
                        st_r <= ST_IDLE;
                    end else if (sie_rx_done) begin
                        hs_valid_r <= 1'b1;
                        hs_code_r  <= rx_stall_r ? HS_STALL : rx_nak_r ? HS_NAK : HS_ACK;
                        st_r       <= ST_IDLE;
                    end
                end
                ST_TX_LOAD: st_r <= ST_TX_SEND;
                ST_TX_SEND: if (sie_tx_ready) begin
                    tx_ptr_r <= tx_ptr_r + CW'(1);
                    st_r     <= tx_end ? ST_WAIT_ACK : ST_TX_LOAD;
                end
                // a lost ACK leaves the bank ready, so the host retry resends it
                ST_WAIT_ACK: if (sie_host_ack || sie_host_timeout) st_r <= ST_IDLE;
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    assign sie_tx_valid = st_r == ST_TX_SEND;
    assign sie_tx_data  = mem_bus.rdata;
    assign sie_tx_empty = tx_len_r == '0;
    assign sie_tx_last  = tx_end;
    assign sie_tx_data1 = tog_r[cur_ep_r];
    assign sie_hs_valid = hs_valid_r;
    assign sie_hs_code  = hs_code_r;
    assign ep_irq       = irq_r;

    // ==========================================================
    // checks
    setup_ack_a: assert property (ce && ev_setup |=> sie_hs_valid && sie_hs_code == HS_ACK)
        else $error("setup packet not acknowledged");
    setup_flag_a: assert property (ce && ev_setup |=> setup_r[$past(cur_ep_r)])
        else $error("setup flag not set");
    setup_irq_a: assert property (ce && setup_r[0] && irq_en_r[0] |=> ep_irq)
        else $error("pending setup did not raise interrupt");
    status_data1_a: assert property (ce && ev_setup |=> tog_r[$past(cur_ep_r)])
        else $error("status stage toggle not DATA1");
    ack_txc_a: assert property (ce && ev_ack |=> txc_r[$past(cur_ep_r)] && st_r == ST_IDLE)
        else $error("host ACK did not set transmit complete");
    in_nak_a: assert property (ce && st_r == ST_IDLE && tok_ok && sie_tok_pid == TOK_IN &&
                               !stall_r[tep] && !full_r[tep][ubank_r[tep]]
                               |=> sie_hs_valid && sie_hs_code == HS_NAK)
        else $error("IN without ready bank not NAKed");
    out_nak_a: assert property (ce && rx_end && !rx_setup_r && rx_nak_r && !rx_stall_r
                                |=> sie_hs_code == HS_NAK && sie_hs_valid)
        else $error("OUT into held bank not NAKed");
    in_stall_a: assert property (ce && st_r == ST_IDLE && tok_ok && sie_tok_pid == TOK_IN &&
                                 stall_r[tep] |=> sie_hs_code == HS_STALL)
        else $error("forced stall not sent");
    bank_alt_a: assert property (ce && ev_ack && dual_r[cur_ep_r] && !csr_wr
                                 |=> ubank_r[$past(cur_ep_r)] != $past(tx_bank_r))
        else $error("send bank did not alternate");
    ctrl_single_a: assert property (st_r == ST_RX && rx_setup_r |-> !dual_r[cur_ep_r])
        else $error("setup accepted on dual-bank endpoint");
    bus_answer_a: assert property (ce && bus_r == BUS_ISSUE && avs_read && !a_fdr ##1 ce
                                   |=> !avs_waitrequest)
        else $error("register read not answered in three cycles");
endmodule // uep_endpoints

// ### design/uep_pkg.sv
// uep_pkg.sv: register map, field layout and codes of the endpoint transaction block
package uep_pkg;

    // ==========================================================
    // register map (byte addresses on the register bus)
    localparam logic [7:0] EP_STRIDE     = 8'h08;
    localparam logic [7:0] FDR_OFFSET    = 8'h04;
    localparam logic [7:0] IRQ_EN_ADDR   = 8'h40;
    localparam logic [7:0] IRQ_PEND_ADDR = 8'h44;
    localparam logic [7:0] ALIGN_MASK    = 8'h03;
    localparam int         EP_SEL_LO     = 3;
    localparam int         FDR_SEL_BIT   = 2;

    // ==========================================================
    // endpoint control/status register fields
    localparam int CSR_TXC    = 0;
    localparam int CSR_RXO    = 1;
    localparam int CSR_SETUP  = 2;
    localparam int CSR_STALL  = 3;
    localparam int CSR_PKTRDY = 4;
    localparam int CSR_DUAL   = 8;
    localparam int CSR_TYPE   = 9;
    localparam int CSR_TOG    = 11;
    localparam int CSR_EN     = 15;
    localparam int CSR_CNT    = 16;

    localparam logic [1:0] TYPE_CTRL = 2'h0;
    localparam logic [1:0] TYPE_ISO  = 2'h1;
    localparam logic [1:0] TYPE_BULK = 2'h2;
    localparam logic [1:0] TYPE_INT  = 2'h3;

    localparam int DEFAULT_CTRL_EP = 0;

    // ==========================================================
    // serial engine side codes
    localparam int         TOK_EP_W  = 4;
    localparam logic [1:0] TOK_SETUP = 2'h0;
    localparam logic [1:0] TOK_OUT   = 2'h1;
    localparam logic [1:0] TOK_IN    = 2'h2;
    localparam logic [1:0] HS_ACK    = 2'h0;
    localparam logic [1:0] HS_NAK    = 2'h1;
    localparam logic [1:0] HS_STALL  = 2'h2;

    // ==========================================================
    // state types
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_TX_LOAD, ST_TX_SEND, ST_WAIT_ACK
    } uep_state_t;

    typedef enum logic [1:0] {BUS_ISSUE, BUS_FETCH, BUS_DONE} uep_bus_t;

endpackage

// ### design/uep_mem_if.sv
// uep_mem_if.sv: endpoint bank memory port between the controller and the memory
`timescale 1ns/10ps
interface uep_mem_if #(
    parameter int AW = 9,
    parameter int DW = 8
);
    logic          we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;

    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ### design/uep_bank_mem.sv
// uep_bank_mem.sv: byte memory holding every bank of every endpoint
`timescale 1ns/10ps
module uep_bank_mem #(
    parameter int AW = 9,
    parameter int DW = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    uep_mem_if.mem   m
);
    // ==========================================================
    // storage
    logic [DW-1:0] ram [2**AW];
    logic [DW-1:0] rdata_r;

    if (AW < 1 || DW < 1) begin : g_chk
        $error("uep_bank_mem: bad geometry");
    end

    always_ff @(posedge clk) begin
        if (ce && m.we) begin
            ram[m.waddr] <= m.wdata;
        end
    end

    // read data is registered so it can feed the serial engine directly
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= '0;
        end else if (ce) begin
            rdata_r <= ram[m.raddr];
        end
    end

    assign m.rdata = rdata_r;
endmodule // uep_bank_mem

// ### verification/uep_host_model.sv
// host side model of the serial engine link
`timescale 1ns/10ps
module uep_host_model (
    input  wire logic       clk,
    input  wire logic       sie_tx_valid,
    input  wire logic [7:0] sie_tx_data,
    input  wire logic       sie_tx_last,
    input  wire logic       sie_tx_empty,
    input  wire logic       sie_tx_data1,
    input  wire logic       sie_hs_valid,
    input  wire logic [1:0] sie_hs_code,
    output logic            sie_tok_valid = 0,
    output logic [1:0]      sie_tok_pid = 0,
    output logic [3:0]      sie_tok_ep = 0,
    output logic            sie_rx_valid = 0,
    output logic [7:0]      sie_rx_data = 0,
    output logic            sie_rx_done = 0,
    output logic            sie_tx_ready = 0,
    output logic            sie_host_ack = 0
);
    logic [7:0] sent[$];
    logic [9:0] got[$];
    logic [1:0] hs[$];
    // ready stalls at random; ack only once the last beat was taken
    always @(posedge clk) begin
        sie_tx_ready <= 1'($urandom);
        sie_host_ack <= sie_tx_valid && sie_tx_ready && sie_tx_last;
        if (sie_tx_valid && sie_tx_ready)
            got.push_back({sie_tx_empty, sie_tx_data1, sie_tx_empty ? 8'h00 : sie_tx_data});
        if (sie_hs_valid)
            hs.push_back(sie_hs_code);
    end
    task automatic tok(input logic [1:0] p, input logic [3:0] e);
        @(posedge clk);
        sie_tok_pid <= p;
        sie_tok_ep <= e;
        sie_tok_valid <= 1;
        @(posedge clk);
        sie_tok_valid <= 0;
    endtask
    // n bytes then a good end; n of zero is the empty status packet
    task automatic pkt(input int n);
        repeat (n) begin
            @(posedge clk);
            sent.push_back(8'($urandom));
            sie_rx_data <= sent[$];
            sie_rx_valid <= 1;
        end
        @(posedge clk);
        sie_rx_valid <= 0;
        sie_rx_data <= ~sie_rx_data;
        sie_rx_done <= 1;
        @(posedge clk);
        sie_rx_done <= 0;
    endtask
endmodule // uep_host_model

// ### verification/test_uep_endpoints.sv
// self-checking bench for the endpoint transaction block
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
    $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module test_uep_endpoints;
    import uep_pkg::*;
    logic        clk = 0, resetn = 0, avs_read = 0, avs_write = 0, avs_waitrequest, ce = 1;
    logic        sie_tok_valid, sie_rx_valid, sie_rx_done, sie_tx_valid, sie_tx_last;
    logic        sie_tx_empty, sie_tx_data1, sie_tx_ready, sie_host_ack, sie_hs_valid, ep_irq;
    logic [1:0]  sie_tok_pid, sie_hs_code, h;
    logic [3:0]  sie_tok_ep, avs_byteenable = 4'hf;
    logic [7:0]  avs_address = 0, sie_rx_data, sie_tx_data, e8, ex[$];
    logic [31:0] avs_writedata = 0, avs_readdata, q;
    logic [9:0]  g;
    int          bad_count = 0, n_tests = 0, cyc = 0, n;
    always #5 clk = ~clk;
    uep_endpoints uep_endpoints_inst (.clk, .resetn, .ce, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .sie_tok_valid, .sie_tok_pid, .sie_tok_ep, .sie_rx_valid, .sie_rx_data, .sie_rx_done,
        .sie_rx_err(1'b0), .sie_tx_valid, .sie_tx_data, .sie_tx_last, .sie_tx_empty,
        .sie_tx_data1, .sie_tx_ready, .sie_host_ack, .sie_host_timeout(1'b0), .sie_hs_valid,
        .sie_hs_code, .ep_irq);
    uep_host_model uep_host_model_inst (.clk, .sie_tx_valid, .sie_tx_data, .sie_tx_last,
        .sie_tx_empty, .sie_tx_data1, .sie_hs_valid, .sie_hs_code, .sie_tok_valid,
        .sie_tok_pid, .sie_tok_ep, .sie_rx_valid, .sie_rx_data, .sie_rx_done, .sie_tx_ready,
        .sie_host_ack);
    // ==========
    // helpers
    function automatic logic [15:0] cs(logic [4:0] f, logic t);
        return {4'h8, t, 6'h00, f};
    endfunction
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        // hold until waitrequest is seen low at a rising edge; read data is taken there
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task automatic hsk(input logic [1:0] c);
        repeat (4) @(posedge clk);
        h = uep_host_model_inst.hs.size() ? uep_host_model_inst.hs.pop_front() : 2'h3;
        `CHK(h, c)
    endtask
    task automatic load(input int k);
        repeat (k) begin
            ex.push_back(8'($urandom));
            bus(1, 8'h0c, {24'h0, ex[$]});
        end
    endtask
    task automatic take(input int k);
        wait (sie_host_ack);
        repeat (3) @(negedge clk);
        repeat (k) begin
            g = uep_host_model_inst.got.size() ? uep_host_model_inst.got.pop_front() : 10'h3ff;
            e8 = ex.pop_front();
            `CHK({g[9], g[7:0]}, {1'b0, e8})
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk) if (++cyc == 20000) begin
        bad_count++;
        complete_run();
    end
    initial begin
        void'($urandom(68));
        repeat (12) @(posedge clk);
        resetn <= 1;
        bus(0, 8'h00, 0);
        `CHK(q, {16'h0, cs(5'h00, 0)})
        bus(0, 8'h48, 0);
        `CHK(q, 32'h0)
        bus(1, IRQ_EN_ADDR, 1);
        uep_host_model_inst.tok(TOK_SETUP, 0);
        uep_host_model_inst.pkt(8);
        hsk(HS_ACK);
        uep_host_model_inst.tok(TOK_OUT, 0);
        uep_host_model_inst.pkt(3);
        hsk(HS_NAK);
        bus(0, 8'h00, 0);
        `CHK(q[22:0], {7'd8, cs(5'h04, 1)})
        `CHK(ep_irq, 1'b1)
        for (n = 0; n < 8; n++) begin
            bus(0, 8'h04, 0);
            `CHK(q[7:0], uep_host_model_inst.sent[n])
        end
        bus(1, IRQ_EN_ADDR, 0);
        repeat (2) @(negedge clk);
        `CHK(ep_irq, 1'b0)
        bus(1, IRQ_EN_ADDR, 1);
        bus(1, 8'h00, 32'h8010);
        uep_host_model_inst.tok(TOK_IN, 0);
        take(0);
        g = uep_host_model_inst.got.pop_front();
        `CHK(g, 10'h300)
        bus(0, 8'h00, 0);
        `CHK(q[15:0], cs(5'h01, 0))
        `CHK(ep_irq, 1'b1)
        bus(1, 8'h00, 32'h8000);
        uep_host_model_inst.tok(TOK_IN, 0);
        hsk(HS_NAK);
        bus(1, 8'h00, 32'h8008);
        uep_host_model_inst.tok(TOK_IN, 0);
        hsk(HS_STALL);
        // two-bank endpoint: second bank filled while the first waits
        bus(1, 8'h08, 32'h8500);
        n = 1 + $urandom_range(7);
        load(n);
        bus(1, 8'h08, 32'h8510);
        load(9 - n);
        uep_host_model_inst.tok(TOK_IN, 1);
        take(n);
        bus(0, 8'h08, 0);
        `CHK(q[4:0], 5'h01)
        bus(1, 8'h08, 32'h8511);
        bus(1, 8'h08, 32'h8500);
        uep_host_model_inst.tok(TOK_IN, 1);
        take(9 - n);
        complete_run();
    end
endmodule // test_uep_endpoints
